// ===== rtl/iq_sample_pkg.sv
// Constants shared by the baseband I/Q sample controller and its shaping filter
package iq_sample_pkg;
  // System clock rate and sample tick rates
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DIG_RATE_HZ = 48_600;
  localparam int unsigned ANA_RATE_HZ = 40_000;
  localparam int unsigned DIG_PERIOD_CYC = CLK_HZ / DIG_RATE_HZ;
  localparam int unsigned ANA_PERIOD_CYC = CLK_HZ / ANA_RATE_HZ;
  localparam int unsigned TICK_W = 10;
  // Cycles the sample tick line stays high after a load
  localparam logic [9:0] IRQ_HIGH_CYC = 10'h080;

  // Data widths
  localparam int unsigned RX_W = 10;
  localparam int unsigned TXI_W = 10;
  localparam int unsigned TXA_W = 8;
  localparam int unsigned DAC_W = 9;
  localparam int unsigned OFS_W = 6;

  // Burst framing counts in sample ticks
  localparam logic [4:0] LEAD_TICKS = 5'h09;
  localparam logic [4:0] TAIL_TICKS = 5'h15;

  // Reset values
  localparam logic [RX_W-1:0] RX_RESET = 10'h000;
  localparam logic [DAC_W-1:0] DAC_RESET = 9'h000;
  localparam logic [OFS_W-1:0] OFS_RESET = 6'h00;

  // Constellation radii on the 9-bit converters
  localparam logic signed [DAC_W-1:0] AMP_FULL = 9'sh0B4;
  localparam logic signed [DAC_W-1:0] AMP_DIAG = 9'sh07F;

  // Square-root raised-cosine taps, roll-off 0.35, two samples a symbol
  localparam int unsigned RRC_TAPS = 9;
  localparam int unsigned COEF_W = 16;
  localparam int unsigned COEF_SHIFT = 7;
  localparam logic signed [COEF_W-1:0] RRC_COEF [RRC_TAPS] = '{
    -16'sh0006, -16'sh000E, 16'sh001E, 16'sh005C, 16'sh0080,
    16'sh005C, 16'sh001E, -16'sh000E, -16'sh0006};

  typedef enum logic [1:0] {BURST_IDLE, BURST_LEAD, BURST_ACTIVE, BURST_TAIL} burst_state_t;
endpackage : iq_sample_pkg

// ===== rtl/root_raised_cosine_filter.sv
// FIR shaping filter stepped once per sample tick, saturating registered output
`timescale 1ns/1ps
module root_raised_cosine_filter #(
  parameter int unsigned DATA_W = iq_sample_pkg::DAC_W,
  parameter int unsigned TAPS = iq_sample_pkg::RRC_TAPS
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_en,
  input wire logic signed [DATA_W-1:0] i_data,
  output logic signed [DATA_W-1:0] o_data
);
  localparam int unsigned ACC_W = DATA_W + iq_sample_pkg::COEF_W + 4;
  localparam logic signed [ACC_W-1:0] MAX_V = ACC_W'(2 ** (DATA_W - 1) - 1);
  localparam logic signed [ACC_W-1:0] MIN_V = -ACC_W'(2 ** (DATA_W - 1));

  typedef struct packed {
    logic [TAPS-1:0][DATA_W-1:0] line;
    logic [DATA_W-1:0] out;
  } flt_state_t;

  flt_state_t s_q;
  flt_state_t s_d;

  // Shift the delay line and form the saturated weighted sum
  always_comb begin
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    s_d = s_q;
    if (i_en) begin
      s_d.line = {s_q.line[TAPS-2:0], i_data};
      for (int k = 0; k < TAPS; k++) begin
        acc = acc + ACC_W'($signed(s_d.line[k]) * iq_sample_pkg::RRC_COEF[k]);
      end
      acc = acc >>> iq_sample_pkg::COEF_SHIFT;
      if (acc > MAX_V) begin
        s_d.out = MAX_V[DATA_W-1:0];
      end else if (acc < MIN_V) begin
        s_d.out = MIN_V[DATA_W-1:0];
      end else begin
        s_d.out = acc[DATA_W-1:0];
      end
    end
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_data = s_q.out;
endmodule : root_raised_cosine_filter

// ===== rtl/cellular_baseband_iq_sample_ctrl.sv
// Receive sample path control, sample tick, and digital/analog transmit path
//
// Operation
// - Analog mode: FM input to Q, other Q to midrail
// - Analog mode: only Q converts, I path off
// - Midrail buffer on when transmit, voice or receive set
// - Digital mode enables both I and Q receive
// - Sample tick after samples load; 48.6/40 kHz
// - Mode bit one digital, zero analog
// - Digital: serialize written data into pi/4 DQPSK
// - Digital: root raised-cosine shaping to 9-bit converters
// - Power amp enable on during transmission
// - Go bit alone starts bursts; go bit low or analog mode stops them
// - Analog: written samples low-pass filtered before conversion
// - Analog mode holds power amp enable high
// - Separate 6-bit I and Q offset trims
// - Receive results in readable 10-bit registers
// - Sample data is two's complement
// - Shift in-phase register right, bit 0 first
// - Go bit sampled on tick falling edge
`timescale 1ns/1ps
module cellular_baseband_iq_sample_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_mode,
  input wire logic i_fm_voice_select,
  input wire logic i_iq_receive_enable,
  input wire logic i_transmit_enable_bit,
  input wire logic i_burst_go_bit,
  input wire logic i_tx_inphase_wr,
  input wire logic [iq_sample_pkg::TXI_W-1:0] i_tx_inphase_wdata,
  input wire logic i_tx_quadrature_wr,
  input wire logic [iq_sample_pkg::TXA_W-1:0] i_tx_quadrature_wdata,
  input wire logic [iq_sample_pkg::OFS_W-1:0] i_tx_offset_i,
  input wire logic [iq_sample_pkg::OFS_W-1:0] i_tx_offset_q,
  input wire logic i_adc_valid,
  input wire logic [iq_sample_pkg::RX_W-1:0] i_adc_i_data,
  input wire logic [iq_sample_pkg::RX_W-1:0] i_adc_q_data,
  output logic o_adc_start,
  output logic o_rx_i_power_en,
  output logic o_rx_q_power_en,
  output logic o_fm_to_q_mux,
  output logic o_rxq_neg_to_midrail,
  output logic o_midrail_reference_en,
  output logic [iq_sample_pkg::RX_W-1:0] o_rx_inphase_sample_reg,
  output logic [iq_sample_pkg::RX_W-1:0] o_rx_quadrature_sample_reg,
  output logic o_sample_tick_irq,
  output logic o_power_amp_enable,
  output logic o_burst_active,
  output logic signed [iq_sample_pkg::DAC_W-1:0] o_dac_i,
  output logic signed [iq_sample_pkg::DAC_W-1:0] o_dac_q,
  output logic [iq_sample_pkg::OFS_W-1:0] o_tx_offset_i,
  output logic [iq_sample_pkg::OFS_W-1:0] o_tx_offset_q
);
  localparam int unsigned TW = iq_sample_pkg::TICK_W;
  localparam int unsigned DW = iq_sample_pkg::DAC_W;
  localparam logic [TW-1:0] DIG_LAST = TW'(iq_sample_pkg::DIG_PERIOD_CYC - 1);
  localparam logic [TW-1:0] ANA_LAST = TW'(iq_sample_pkg::ANA_PERIOD_CYC - 1);

  typedef struct packed {
    logic [TW-1:0] tick_cnt;
    logic adc_start;
    logic conv_pending;
    logic irq;
    logic [9:0] irq_cnt;
    logic [iq_sample_pkg::RX_W-1:0] rx_i;
    logic [iq_sample_pkg::RX_W-1:0] rx_q;
    logic rx_i_pwr;
    logic rx_q_pwr;
    logic fm_mux;
    logic rxq_mid;
    logic mid_en;
    iq_sample_pkg::burst_state_t burst;
    logic busy;
    logic [4:0] burst_cnt;
    logic [iq_sample_pkg::TXI_W-1:0] tx_inphase_data_reg;
    logic [iq_sample_pkg::TXA_W-1:0] tx_quadrature_data_reg;
    logic half;
    logic held_bit;
    logic [2:0] phase;
    logic flt_en;
    logic [DW-1:0] flt_i;
    logic [DW-1:0] flt_q;
    logic pa;
    logic [iq_sample_pkg::OFS_W-1:0] ofs_i;
    logic [iq_sample_pkg::OFS_W-1:0] ofs_q;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [DW-1:0] flt_out_i;
  logic [DW-1:0] flt_out_q;

  // Phase advance in eighths of a turn for a dibit, first bit in the high place
  function automatic logic [2:0] dqpsk_step(input logic [1:0] dibit);
    unique case (dibit)
      2'b00: dqpsk_step = 3'h1;
      2'b01: dqpsk_step = 3'h3;
      2'b10: dqpsk_step = 3'h7;
      2'b11: dqpsk_step = 3'h5;
    endcase
  endfunction : dqpsk_step

  // Constellation point for a phase, I in the high half
  function automatic logic [2*DW-1:0] point_of(input logic [2:0] ph);
    logic signed [DW-1:0] f;
    logic signed [DW-1:0] g;
    f = iq_sample_pkg::AMP_FULL;
    g = iq_sample_pkg::AMP_DIAG;
    unique case (ph)
      3'h0: point_of = {f, 9'sh000};
      3'h1: point_of = {g, g};
      3'h2: point_of = {9'sh000, f};
      3'h3: point_of = {-g, g};
      3'h4: point_of = {-f, 9'sh000};
      3'h5: point_of = {-g, -g};
      3'h6: point_of = {9'sh000, -f};
      3'h7: point_of = {g, -g};
    endcase
  endfunction : point_of

  // Next-state logic for sample timing, receive control and transmit path
  always_comb begin
    logic tick;
    logic bit_out;
    logic [2:0] ph_new;
    logic [2*DW-1:0] pt;
    tick = 1'b0;
    bit_out = 1'b0;
    ph_new = s_q.phase;
    pt = '0;
    s_d = s_q;
    s_d.adc_start = 1'b0;
    s_d.flt_en = 1'b0;

    // Receive path steering from mode and enables
    s_d.fm_mux = ~i_mode & i_fm_voice_select;
    s_d.rxq_mid = ~i_mode & i_fm_voice_select;
    s_d.rx_i_pwr = i_mode & i_iq_receive_enable;
    s_d.rx_q_pwr = i_mode ? i_iq_receive_enable : i_fm_voice_select;
    s_d.mid_en = i_transmit_enable_bit | i_fm_voice_select | i_iq_receive_enable;
    s_d.ofs_i = i_tx_offset_i;
    s_d.ofs_q = i_tx_offset_q;

    // Load results, raise the tick line; registers hold otherwise
    if (s_q.conv_pending && i_adc_valid) begin
      s_d.conv_pending = 1'b0;
      s_d.rx_q = i_adc_q_data;
      if (i_mode) begin
        s_d.rx_i = i_adc_i_data;
      end
      s_d.irq = 1'b1;
      s_d.irq_cnt = iq_sample_pkg::IRQ_HIGH_CYC;
    end else if (s_q.irq) begin
      if (s_q.irq_cnt == 10'h001) begin
        s_d.irq = 1'b0;
        tick = 1'b1;
      end
      s_d.irq_cnt = s_q.irq_cnt - 1'b1;
    end

    // Conversion pacing; a new start wins over a result taken in the same cycle
    if (s_q.tick_cnt >= (i_mode ? DIG_LAST : ANA_LAST)) begin
      s_d.tick_cnt = '0;
      s_d.adc_start = 1'b1;
      s_d.conv_pending = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end

    // DSP writes to the transmit data registers
    if (i_tx_inphase_wr) begin
      s_d.tx_inphase_data_reg = i_tx_inphase_wdata;
    end
    if (i_tx_quadrature_wr) begin
      s_d.tx_quadrature_data_reg = i_tx_quadrature_wdata;
    end

    // Transmit work on each falling edge of the tick line
    if (tick) begin
      s_d.flt_en = 1'b1;
      if (!i_mode) begin
        // Analog: written two's complement samples feed the low-pass filter
        s_d.burst = iq_sample_pkg::BURST_IDLE;
        s_d.phase = '0;
        s_d.half = 1'b0;
        s_d.flt_i = {s_q.tx_inphase_data_reg[iq_sample_pkg::TXA_W-1:0], 1'b0};
        s_d.flt_q = {s_q.tx_quadrature_data_reg, 1'b0};
      end else begin
        s_d.flt_i = '0;
        s_d.flt_q = '0;
        unique case (s_q.burst)
          iq_sample_pkg::BURST_IDLE: begin
            s_d.phase = '0;
            s_d.half = 1'b0;
            if (i_burst_go_bit) begin
              s_d.burst = iq_sample_pkg::BURST_LEAD;
              s_d.burst_cnt = iq_sample_pkg::LEAD_TICKS;
            end
          end
          iq_sample_pkg::BURST_LEAD: begin
            s_d.burst_cnt = s_q.burst_cnt - 1'b1;
            if (s_q.burst_cnt == 5'h01) begin
              s_d.burst = iq_sample_pkg::BURST_ACTIVE;
            end
          end
          iq_sample_pkg::BURST_ACTIVE: begin
            bit_out = s_q.tx_inphase_data_reg[0];
            if (!i_tx_inphase_wr) begin
              s_d.tx_inphase_data_reg = s_q.tx_inphase_data_reg >> 1;
            end
            if (!s_q.half) begin
              s_d.held_bit = bit_out;
              s_d.half = 1'b1;
            end else begin
              ph_new = s_q.phase + dqpsk_step({s_q.held_bit, bit_out});
              pt = point_of(ph_new);
              s_d.phase = ph_new;
              s_d.half = 1'b0;
              s_d.flt_i = pt[2*DW-1:DW];
              s_d.flt_q = pt[DW-1:0];
            end
            if (!i_burst_go_bit) begin
              s_d.burst = iq_sample_pkg::BURST_TAIL;
              s_d.burst_cnt = iq_sample_pkg::TAIL_TICKS;
            end
          end
          iq_sample_pkg::BURST_TAIL: begin
            s_d.burst_cnt = s_q.burst_cnt - 1'b1;
            if (s_q.burst_cnt == 5'h01) begin
              s_d.burst = iq_sample_pkg::BURST_IDLE;
            end
          end
        endcase
      end
    end

    // Power amp: always on in analog mode, else from end of lead through end of tail
    s_d.pa = ~i_mode
           | (s_d.burst == iq_sample_pkg::BURST_ACTIVE)
           | (s_d.burst == iq_sample_pkg::BURST_TAIL);
    // Burst flag kept in a flop so the output needs no decode
    s_d.busy = (s_d.burst != iq_sample_pkg::BURST_IDLE);
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.rx_i <= iq_sample_pkg::RX_RESET;
      s_q.rx_q <= iq_sample_pkg::RX_RESET;
      s_q.ofs_i <= iq_sample_pkg::OFS_RESET;
      s_q.ofs_q <= iq_sample_pkg::OFS_RESET;
      s_q.burst <= iq_sample_pkg::BURST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Shaping filter for I; also the analog-mode low-pass
  root_raised_cosine_filter #(.DATA_W(DW), .TAPS(iq_sample_pkg::RRC_TAPS)) u_flt_i (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(s_q.flt_en),
    .i_data(s_q.flt_i),
    .o_data(flt_out_i)
  );

  // Shaping filter for Q
  root_raised_cosine_filter #(.DATA_W(DW), .TAPS(iq_sample_pkg::RRC_TAPS)) u_flt_q (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_en(s_q.flt_en),
    .i_data(s_q.flt_q),
    .o_data(flt_out_q)
  );

  // Outputs, all straight from flip-flops
  assign o_adc_start = s_q.adc_start;
  assign o_rx_i_power_en = s_q.rx_i_pwr;
  assign o_rx_q_power_en = s_q.rx_q_pwr;
  assign o_fm_to_q_mux = s_q.fm_mux;
  assign o_rxq_neg_to_midrail = s_q.rxq_mid;
  assign o_midrail_reference_en = s_q.mid_en;
  assign o_rx_inphase_sample_reg = s_q.rx_i;
  assign o_rx_quadrature_sample_reg = s_q.rx_q;
  assign o_sample_tick_irq = s_q.irq;
  assign o_power_amp_enable = s_q.pa;
  assign o_burst_active = s_q.busy;
  assign o_dac_i = flt_out_i;
  assign o_dac_q = flt_out_q;
  assign o_tx_offset_i = s_q.ofs_i;
  assign o_tx_offset_q = s_q.ofs_q;
endmodule : cellular_baseband_iq_sample_ctrl

// ===== sim/cellular_baseband_iq_sample_ctrl_sva.sv
// Port-level checker for the baseband I/Q sample controller
`timescale 1ns/1ps
module iq_ctrl_checker (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_mode,
  input wire logic i_fm_voice_select,
  input wire logic i_iq_receive_enable,
  input wire logic i_transmit_enable_bit,
  input wire logic i_adc_valid,
  input wire logic [iq_sample_pkg::RX_W-1:0] i_adc_q_data,
  input wire logic [iq_sample_pkg::OFS_W-1:0] i_tx_offset_i,
  input wire logic o_rx_i_power_en,
  input wire logic o_fm_to_q_mux,
  input wire logic o_rxq_neg_to_midrail,
  input wire logic o_midrail_reference_en,
  input wire logic [iq_sample_pkg::RX_W-1:0] o_rx_quadrature_sample_reg,
  input wire logic o_sample_tick_irq,
  input wire logic o_power_amp_enable,
  input wire logic o_burst_active,
  input wire logic [iq_sample_pkg::OFS_W-1:0] o_tx_offset_i
);
  logic [7:0] hi_cnt_q;
  // Counts cycles the sample tick line has stayed high
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !o_sample_tick_irq) begin
      hi_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= hi_cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  a_rx_i_power: assert property (!$past(i_sys_rst) |->
    o_rx_i_power_en == $past(i_mode && i_iq_receive_enable)) else $error("I power wrong");
  a_fm_steer: assert property (!$past(i_sys_rst) && $past(!i_mode && i_fm_voice_select)
    |-> o_fm_to_q_mux && o_rxq_neg_to_midrail) else $error("FM steering wrong");
  a_midrail_or: assert property (!$past(i_sys_rst) |-> o_midrail_reference_en ==
    $past(i_transmit_enable_bit || i_fm_voice_select || i_iq_receive_enable))
    else $error("midrail enable wrong");
  a_analog_pa_high: assert property (!$past(i_sys_rst) && !$past(i_mode)
    |-> o_power_amp_enable) else $error("pa low in analog");
  a_idle_pa_off: assert property ($past(i_mode, 2) && $past(i_mode) &&
    !$past(o_burst_active) && !o_burst_active |-> !o_power_amp_enable) else $error("pa idle");
  a_tick_cause: assert property ($rose(o_sample_tick_irq) |-> $past(i_adc_valid))
    else $error("tick without conversion");
  a_tick_width: assert property ($fell(o_sample_tick_irq) |-> hi_cnt_q == 8'h80)
    else $error("tick width wrong");
  a_rxq_load: assert property ($rose(o_sample_tick_irq) |->
    o_rx_quadrature_sample_reg == $past(i_adc_q_data)) else $error("Q sample wrong");
  a_rx_hold: assert property (!$rose(o_sample_tick_irq) |->
    $stable(o_rx_quadrature_sample_reg)) else $error("Q sample moved");
  a_offset_copy: assert property (!$past(i_sys_rst) |->
    o_tx_offset_i == $past(i_tx_offset_i)) else $error("offset wrong");
  c_burst: cover property ($rose(o_burst_active));
  c_pa_rise: cover property ($rose(o_power_amp_enable) && i_mode);
  c_tick_analog: cover property ($rose(o_sample_tick_irq) && !i_mode);
endmodule : iq_ctrl_checker

// ===== sim/adc_partner_model.sv
// Behavioural receive converter answering each conversion start
`timescale 1ns/1ps
module adc_partner_model (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic i_start,
  output logic o_valid,
  output logic [iq_sample_pkg::RX_W-1:0] o_i_data,
  output logic [iq_sample_pkg::RX_W-1:0] o_q_data
);
  int wait_cnt = -1;
  logic [9:0] code = 10'h3F0;
  initial begin
    o_valid = 1'b0;
    o_i_data = 10'h000;
    o_q_data = 10'h000;
  end
  // Short or long latency; data lines churn every cycle outside the result
  always @(posedge i_sys_clk) begin
    o_valid <= 1'b0;
    o_i_data <= ~o_i_data;
    o_q_data <= o_q_data + 10'h155;
    if (i_start) begin
      wait_cnt = i_slow ? 40 : 2;
    end else if (wait_cnt > 0) begin
      wait_cnt = wait_cnt - 1;
    end else if (wait_cnt == 0) begin
      wait_cnt = -1;
      code = code + 10'h023; // Signed codes walk through zero
      o_valid <= 1'b1; // One result per start
      o_i_data <= code;
      o_q_data <= ~code;
    end
  end
endmodule : adc_partner_model

// ===== sim/tb_cellular_baseband_iq_sample_ctrl.sv
// Self-checking bench for the baseband I/Q sample controller
`timescale 1ns/1ps
module tb_cellular_baseband_iq_sample_ctrl;
  logic i_sys_clk, i_sys_rst, i_mode, i_fm_voice_select, i_iq_receive_enable;
  logic i_transmit_enable_bit, i_burst_go_bit, i_tx_inphase_wr, i_tx_quadrature_wr, slow;
  logic [9:0] i_tx_inphase_wdata, exp_i, exp_q;
  logic [7:0] i_tx_quadrature_wdata;
  logic [5:0] i_tx_offset_i, i_tx_offset_q, o_tx_offset_i, o_tx_offset_q;
  logic i_adc_valid, o_adc_start, o_rx_i_power_en, o_rx_q_power_en, o_fm_to_q_mux;
  logic o_rxq_neg_to_midrail, o_midrail_reference_en, o_sample_tick_irq;
  logic o_power_amp_enable, o_burst_active;
  logic [9:0] i_adc_i_data, i_adc_q_data, o_rx_inphase_sample_reg, o_rx_quadrature_sample_reg;
  logic signed [8:0] o_dac_i, o_dac_q;
  int bad_count = 0;
  int num_checks = 0;
  cellular_baseband_iq_sample_ctrl u_cellular_baseband_iq_sample_ctrl (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_mode(i_mode),
    .i_fm_voice_select(i_fm_voice_select), .i_iq_receive_enable(i_iq_receive_enable),
    .i_transmit_enable_bit(i_transmit_enable_bit), .i_burst_go_bit(i_burst_go_bit),
    .i_tx_inphase_wr(i_tx_inphase_wr), .i_tx_inphase_wdata(i_tx_inphase_wdata),
    .i_tx_quadrature_wr(i_tx_quadrature_wr), .i_tx_quadrature_wdata(i_tx_quadrature_wdata),
    .i_tx_offset_i(i_tx_offset_i), .i_tx_offset_q(i_tx_offset_q),
    .i_adc_valid(i_adc_valid), .i_adc_i_data(i_adc_i_data), .i_adc_q_data(i_adc_q_data),
    .o_adc_start(o_adc_start), .o_rx_i_power_en(o_rx_i_power_en),
    .o_rx_q_power_en(o_rx_q_power_en), .o_fm_to_q_mux(o_fm_to_q_mux),
    .o_rxq_neg_to_midrail(o_rxq_neg_to_midrail),
    .o_midrail_reference_en(o_midrail_reference_en),
    .o_rx_inphase_sample_reg(o_rx_inphase_sample_reg),
    .o_rx_quadrature_sample_reg(o_rx_quadrature_sample_reg),
    .o_sample_tick_irq(o_sample_tick_irq), .o_power_amp_enable(o_power_amp_enable),
    .o_burst_active(o_burst_active), .o_dac_i(o_dac_i), .o_dac_q(o_dac_q),
    .o_tx_offset_i(o_tx_offset_i), .o_tx_offset_q(o_tx_offset_q));
  adc_partner_model u_adc_partner_model (.i_sys_clk(i_sys_clk), .i_slow(slow),
    .i_start(o_adc_start), .o_valid(i_adc_valid), .o_i_data(i_adc_i_data),
    .o_q_data(i_adc_q_data));
  // Clock and the converter result the registers should show
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    if (i_adc_valid) begin
      exp_i <= i_adc_i_data;
      exp_q <= i_adc_q_data;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : check
  function automatic logic sig(input int s);
    case (s)
      0: return o_adc_start;
      1: return o_sample_tick_irq;
      2: return o_burst_active;
      default: return o_power_amp_enable;
    endcase
  endfunction : sig
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge i_sys_clk);
      n++;
    end
  endtask : wait_sig
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // Walks all sixteen mode and enable combinations
  task automatic steering_test();
    for (int k = 0; k < 16; k++) begin
      @(posedge i_sys_clk);
      {i_mode, i_fm_voice_select, i_iq_receive_enable, i_transmit_enable_bit} <= k[3:0];
      repeat (2) @(posedge i_sys_clk);
      #1;
      check(o_rx_i_power_en, k[3] & k[1]);
      check(o_rx_q_power_en, k[3] ? k[1] : k[2]);
      check(o_midrail_reference_en, |k[2:0]);
      check(o_power_amp_enable, !k[3]);
      check({o_fm_to_q_mux, o_rxq_neg_to_midrail}, {2{!k[3] & k[2]}});
    end
    $display("steering test done");
  endtask : steering_test
  // Measures the tick period and checks loaded and held samples
  task automatic rx_round(input logic md, input logic sl);
    int n;
    logic [9:0] held_i;
    @(posedge i_sys_clk);
    {i_mode, i_fm_voice_select, i_iq_receive_enable, slow} <= {md, !md, md, sl};
    wait_sig(0, 1, 2000);
    @(posedge i_sys_clk);
    wait_sig(0, 1, 2000);
    held_i = o_rx_inphase_sample_reg;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_adc_start !== 1'b1 && n < 2000);
    check(n, md ? iq_sample_pkg::DIG_PERIOD_CYC : iq_sample_pkg::ANA_PERIOD_CYC);
    wait_sig(1, 0, 2000);
    wait_sig(1, 1, 2000);
    repeat (2) begin
      check(o_rx_quadrature_sample_reg, exp_q);
      check(o_rx_inphase_sample_reg, md ? exp_i : held_i);
      repeat (200) @(posedge i_sys_clk);
    end
    $display("receive round done");
  endtask : rx_round
  // Analog transmit: offsets, low-pass filtered sample signs, go ignored
  task automatic analog_tx_test();
    @(posedge i_sys_clk);
    {i_mode, i_burst_go_bit, i_tx_offset_i, i_tx_offset_q} <= {2'b01, 6'h2A, 6'h15};
    {i_tx_inphase_wr, i_tx_quadrature_wr} <= 2'b11;
    {i_tx_inphase_wdata, i_tx_quadrature_wdata} <= {10'h3F0, 8'h10};
    @(posedge i_sys_clk);
    {i_tx_inphase_wr, i_tx_quadrature_wr} <= 2'b00;
    repeat (2) @(posedge i_sys_clk);
    check({o_tx_offset_i, o_tx_offset_q}, {6'h2A, 6'h15});
    repeat (12 * 625) @(posedge i_sys_clk);
    #1;
    check({o_burst_active, o_power_amp_enable}, 2'b01);
    check({o_dac_i[8], o_dac_q[8], o_dac_q == 9'sh000}, 3'b100);
    $display("analog transmit test done");
  endtask : analog_tx_test
  // Digital burst framed by the go bit alone, lead length and shaped output
  task automatic burst_test();
    int n;
    @(posedge i_sys_clk);
    {i_mode, i_iq_receive_enable, i_burst_go_bit, i_tx_inphase_wr} <= 4'b1101;
    i_tx_inphase_wdata <= 10'h2D5;
    @(posedge i_sys_clk);
    i_tx_inphase_wr <= 1'b0;
    @(posedge i_sys_clk);
    check({o_burst_active, o_power_amp_enable}, 2'b00);
    i_burst_go_bit <= 1'b1;
    wait_sig(2, 1, 1200);
    #1;
    check({o_burst_active, o_power_amp_enable}, 2'b10);
    n = 0;
    while (o_power_amp_enable !== 1'b1 && n < 6500) begin
      @(posedge i_sys_clk);
      n++;
    end
    check(n, iq_sample_pkg::LEAD_TICKS * iq_sample_pkg::DIG_PERIOD_CYC);
    check(o_power_amp_enable, 1'b1);
    // Four symbols into the burst the shaped outputs have left zero
    repeat (8 * iq_sample_pkg::DIG_PERIOD_CYC) @(posedge i_sys_clk);
    #1;
    check({o_dac_i, o_dac_q} != 18'h0_0000, 1'b1);
    @(posedge i_sys_clk);
    i_burst_go_bit <= 1'b0;
    wait_sig(3, 0, 13500);
    repeat (2) @(posedge i_sys_clk);
    #1;
    check({o_burst_active, o_power_amp_enable}, 2'b00);
    check({o_dac_i, o_dac_q}, 18'h0_0000);
    $display("burst test done");
  endtask : burst_test
  // Main sequence
  initial begin
    {i_sys_rst, i_mode, i_fm_voice_select, i_iq_receive_enable} = 4'b1000;
    {i_transmit_enable_bit, i_burst_go_bit, i_tx_inphase_wr, i_tx_quadrature_wr} = 4'b0000;
    {slow, i_tx_inphase_wdata, i_tx_quadrature_wdata} = {1'b0, 10'h000, 8'h00};
    {i_tx_offset_i, i_tx_offset_q} = 12'h000;
    repeat (10) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    steering_test();
    rx_round(1'b1, 1'b0);
    rx_round(1'b1, 1'b1);
    rx_round(1'b0, 1'b1);
    rx_round(1'b0, 1'b0);
    analog_tx_test();
    burst_test();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    bad_count++;
    conclude();
  end
endmodule : tb_cellular_baseband_iq_sample_ctrl
bind cellular_baseband_iq_sample_ctrl iq_ctrl_checker u_iq_ctrl_checker (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_mode(i_mode),
  .i_fm_voice_select(i_fm_voice_select), .i_iq_receive_enable(i_iq_receive_enable),
  .i_transmit_enable_bit(i_transmit_enable_bit), .i_adc_valid(i_adc_valid),
  .i_adc_q_data(i_adc_q_data), .i_tx_offset_i(i_tx_offset_i),
  .o_rx_i_power_en(o_rx_i_power_en), .o_fm_to_q_mux(o_fm_to_q_mux),
  .o_rxq_neg_to_midrail(o_rxq_neg_to_midrail), .o_midrail_reference_en(o_midrail_reference_en),
  .o_rx_quadrature_sample_reg(o_rx_quadrature_sample_reg),
  .o_sample_tick_irq(o_sample_tick_irq), .o_power_amp_enable(o_power_amp_enable),
  .o_burst_active(o_burst_active), .o_tx_offset_i(o_tx_offset_i));
